// ---- src/op_pkg.sv ----
// package: decode classes, operand sources, instruction layout and timing counts
package op_pkg;
  // ==============================
  // timing and field layout
  localparam logic [3:0] CYC_SHORT = 4'h2;
  localparam logic [3:0] CYC_LONG = 4'h4;
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam int PAGE_MSB = 7;
  localparam int PAGE_LSB = 5;
  localparam int ABS_W = 11;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] OP_DP_LOAD = 8'h90;
  localparam logic [7:0] OP_LONG_JUMP = 8'h02;

  // ==============================
  // instruction classes
  typedef enum logic [5:0] {
    c_undef, c_nop, c_mov_a, c_mov_reg, c_mov_dir, c_mov_ind, c_mov_dp,
    c_code_load, c_xdata_rd, c_xdata_wr, c_push, c_pop, c_xch, c_xch_nib,
    c_c_and, c_c_andn, c_c_or, c_c_orn, c_bit_to_c, c_c_to_bit,
    c_abs_call, c_abs_jump, c_long_call, c_long_jump, c_short_jump,
    c_ret, c_int_return, c_jmp_ind, c_jc, c_jnc, c_jz, c_jnz,
    c_jb, c_jnb, c_bit_clr_br, c_cmp_br, c_dec_br
  } op_class_t;

  // where the moved or tested operand comes from
  typedef enum logic [3:0] {
    s_none, s_acc, s_reg, s_dir, s_ind, s_imm, s_dp, s_pc, s_bit
  } src_t;

  // ==============================
  // carriers
  typedef struct packed {
    op_class_t cls;
    src_t src;
    logic [1:0] len;
    logic [3:0] cyc;
    logic [2:0] reg_sel;
  } decoded_t;

  typedef struct packed {
    decoded_t dec;
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
  } instr_t;
endpackage

// ---- src/exec_cycle_timer.sv ----
// execute phase timer: holds for a loaded number of clock cycles
`timescale 1ns/10ps
module exec_cycle_timer #(
  parameter int CNT_W = 4
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [CNT_W-1:0] count_i,
  output logic busy_o,
  output logic last_o
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  if (CNT_W < 3) begin : g_width_check
    $error("CNT_W cannot hold the longest cycle count");
  end

  always_comb begin
    next_count = count;
    if (load_i) begin
      next_count = count_i;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign busy_o = (count != '0);
  assign last_o = (count == CNT_W'(1));
endmodule

// ---- src/branch_target_unit.sv ----
// branch destination and code-byte address arithmetic
`timescale 1ns/10ps
module branch_target_unit #(
  parameter int PC_W = 16
) (
  input wire logic [PC_W-1:0] pc_next_i,
  input wire op_pkg::instr_t instr_i,
  input wire logic [7:0] acc_i,
  input wire logic [15:0] data_pointer_i,
  output logic [PC_W-1:0] target_o,
  output logic [PC_W-1:0] code_addr_o
);
  logic [7:0] rel;

  // unsigned accumulator offset added to a base address
  function automatic logic [PC_W-1:0] add_acc(input logic [PC_W-1:0] base,
                                              input logic [7:0] a);
    add_acc = base + {{(PC_W-8){1'b0}}, a};
  endfunction

  always_comb begin
    rel = (instr_i.dec.len == op_pkg::LEN_3) ? instr_i.byte2 : instr_i.byte1;
    target_o = pc_next_i;
    case (instr_i.dec.cls)
      op_pkg::c_abs_call, op_pkg::c_abs_jump: begin
        target_o = {pc_next_i[PC_W-1:op_pkg::ABS_W],
                    instr_i.opcode[op_pkg::PAGE_MSB:op_pkg::PAGE_LSB],
                    instr_i.byte1};
      end
      op_pkg::c_long_call, op_pkg::c_long_jump: begin
        target_o = PC_W'({instr_i.byte1, instr_i.byte2});
      end
      op_pkg::c_jmp_ind: begin
        target_o = add_acc(PC_W'(data_pointer_i), acc_i);
      end
      op_pkg::c_short_jump, op_pkg::c_jc, op_pkg::c_jnc, op_pkg::c_jz,
      op_pkg::c_jnz, op_pkg::c_jb, op_pkg::c_jnb, op_pkg::c_bit_clr_br,
      op_pkg::c_cmp_br, op_pkg::c_dec_br: begin
        target_o = pc_next_i + {{(PC_W-8){rel[7]}}, rel};
      end
      default: begin
        target_o = pc_next_i;
      end
    endcase
    // the pc form uses the address of the following instruction
    if (instr_i.dec.src == op_pkg::s_pc) begin
      code_addr_o = add_acc(pc_next_i, acc_i);
    end else begin
      code_addr_o = add_acc(PC_W'(data_pointer_i), acc_i);
    end
  end
endmodule

// ---- src/cpu_opcode_decode_transfer_branch.sv ----
// top: opcode fetch, decode and execute timing for transfer and branch groups
`timescale 1ns/10ps
// Contract
// - eight-code blocks select bank register from low bits
// - absolute call/jump take page from opcode top
// - accumulator loads decode, two cycles each
// - bank register moves decode with their cycles
// - direct byte moves decode with their cycles
// - indirect memory moves decode with their cycles
// - 0x90 loads data pointer, three bytes, four
// - code byte read at accumulator plus base
// - external reads: pointer or data pointer, four
// - external writes: pointer or data pointer, four
// - push and pop direct byte, four cycles
// - exchanges two cycles, low nibble form too
// - carry logic with direct bits, four cycles
// - bit to carry two, carry to bit four
// - long call, return, interrupt return: four cycles
// - long jump and short jump: four cycles
// - relative branches on carry or accumulator zero
// - bit-test branches, one also clears bit
// - 0x73 jumps to accumulator plus data pointer
// - compare-and-branch forms decode, four cycles
// - decrement-and-branch forms decode, four cycles
// - cycles in clocks; length sets fetched bytes
module cpu_opcode_decode_transfer_branch #(
  parameter int PC_W = 16
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] code_byte_i,
  input wire logic code_valid_i,
  output logic code_ready_o,
  input wire logic [7:0] acc_i,
  input wire logic [15:0] data_pointer_i,
  input wire logic carry_i,
  input wire logic test_i,
  output op_pkg::instr_t instr_o,
  output logic instr_valid_o,
  output logic exec_busy_o,
  output logic exec_done_o,
  output logic [PC_W-1:0] pc_o,
  output logic [PC_W-1:0] target_o,
  output logic [PC_W-1:0] code_addr_o,
  output logic branch_taken_o,
  output logic bit_clear_o
);
  typedef enum logic [1:0] {st_opcode, st_operand, st_exec} state_t;

  state_t state;
  state_t next_state;
  op_pkg::instr_t next_instr;
  op_pkg::decoded_t dec_now;
  logic [PC_W-1:0] next_pc;
  logic [1:0] idx;
  logic [1:0] next_idx;
  logic next_issue;
  logic [PC_W-1:0] next_target;
  logic [PC_W-1:0] next_code_addr;
  logic timer_last;
  logic taken;
  logic [1:0] nbytes;

  if (PC_W < 16) begin : g_pc_check
    $error("PC_W must hold a full 16-bit destination");
  end

  // ==============================
  // decode table
  function automatic op_pkg::decoded_t mk(input op_pkg::op_class_t c,
                                          input op_pkg::src_t s,
                                          input int l, input bit lng);
    op_pkg::decoded_t d;
    d.cls = c;
    d.src = s;
    d.len = 2'(l);
    d.cyc = lng ? op_pkg::CYC_LONG : op_pkg::CYC_SHORT;
    d.reg_sel = 3'h0;
    return d;
  endfunction

  function automatic op_pkg::decoded_t decode(input logic [7:0] op);
    op_pkg::decoded_t d;
    // anything not listed is a one-byte, two-cycle no-effect slot
    d = mk(op_pkg::c_undef, op_pkg::s_none, 1, 1'b0);
    case (op) inside
      8'h00: d = mk(op_pkg::c_nop, op_pkg::s_none, 1, 1'b0);
      // accumulator loads
      [8'hE8:8'hEF]: d = mk(op_pkg::c_mov_a, op_pkg::s_reg, 1, 1'b0);
      8'hE5: d = mk(op_pkg::c_mov_a, op_pkg::s_dir, 2, 1'b0);
      [8'hE6:8'hE7]: d = mk(op_pkg::c_mov_a, op_pkg::s_ind, 1, 1'b0);
      8'h74: d = mk(op_pkg::c_mov_a, op_pkg::s_imm, 2, 1'b0);
      // bank register destination
      [8'hF8:8'hFF]: d = mk(op_pkg::c_mov_reg, op_pkg::s_acc, 1, 1'b0);
      [8'hA8:8'hAF]: d = mk(op_pkg::c_mov_reg, op_pkg::s_dir, 2, 1'b1);
      [8'h78:8'h7F]: d = mk(op_pkg::c_mov_reg, op_pkg::s_imm, 2, 1'b0);
      // direct byte destination
      8'hF5: d = mk(op_pkg::c_mov_dir, op_pkg::s_acc, 2, 1'b0);
      [8'h88:8'h8F]: d = mk(op_pkg::c_mov_dir, op_pkg::s_reg, 2, 1'b1);
      8'h85: d = mk(op_pkg::c_mov_dir, op_pkg::s_dir, 3, 1'b1);
      [8'h86:8'h87]: d = mk(op_pkg::c_mov_dir, op_pkg::s_ind, 2, 1'b1);
      8'h75: d = mk(op_pkg::c_mov_dir, op_pkg::s_imm, 3, 1'b1);
      // indirect destination
      [8'hF6:8'hF7]: d = mk(op_pkg::c_mov_ind, op_pkg::s_acc, 1, 1'b0);
      [8'hA6:8'hA7]: d = mk(op_pkg::c_mov_ind, op_pkg::s_dir, 2, 1'b1);
      [8'h76:8'h77]: d = mk(op_pkg::c_mov_ind, op_pkg::s_imm, 2, 1'b0);
      op_pkg::OP_DP_LOAD: d = mk(op_pkg::c_mov_dp, op_pkg::s_imm, 3, 1'b1);
      8'h93: d = mk(op_pkg::c_code_load, op_pkg::s_dp, 1, 1'b1);
      8'h83: d = mk(op_pkg::c_code_load, op_pkg::s_pc, 1, 1'b1);
      // external data: pointer register gives 8 bits, data pointer 16
      [8'hE2:8'hE3]: d = mk(op_pkg::c_xdata_rd, op_pkg::s_ind, 1, 1'b1);
      8'hE0: d = mk(op_pkg::c_xdata_rd, op_pkg::s_dp, 1, 1'b1);
      [8'hF2:8'hF3]: d = mk(op_pkg::c_xdata_wr, op_pkg::s_ind, 1, 1'b1);
      8'hF0: d = mk(op_pkg::c_xdata_wr, op_pkg::s_dp, 1, 1'b1);
      8'hC0: d = mk(op_pkg::c_push, op_pkg::s_dir, 2, 1'b1);
      8'hD0: d = mk(op_pkg::c_pop, op_pkg::s_dir, 2, 1'b1);
      [8'hC8:8'hCF]: d = mk(op_pkg::c_xch, op_pkg::s_reg, 1, 1'b0);
      8'hC5: d = mk(op_pkg::c_xch, op_pkg::s_dir, 2, 1'b0);
      [8'hC6:8'hC7]: d = mk(op_pkg::c_xch, op_pkg::s_ind, 1, 1'b0);
      [8'hD6:8'hD7]: d = mk(op_pkg::c_xch_nib, op_pkg::s_ind, 1, 1'b0);
      // carry logic
      8'h82: d = mk(op_pkg::c_c_and, op_pkg::s_bit, 2, 1'b1);
      8'hB0: d = mk(op_pkg::c_c_andn, op_pkg::s_bit, 2, 1'b1);
      8'h72: d = mk(op_pkg::c_c_or, op_pkg::s_bit, 2, 1'b1);
      8'hA0: d = mk(op_pkg::c_c_orn, op_pkg::s_bit, 2, 1'b1);
      8'hA2: d = mk(op_pkg::c_bit_to_c, op_pkg::s_bit, 2, 1'b0);
      8'h92: d = mk(op_pkg::c_c_to_bit, op_pkg::s_bit, 2, 1'b1);
      // branching; bit 4 splits the absolute call and jump pages
      8'h?1: begin
        d = mk(op[4] ? op_pkg::c_abs_call : op_pkg::c_abs_jump,
               op_pkg::s_none, 2, 1'b1);
      end
      8'h12: d = mk(op_pkg::c_long_call, op_pkg::s_imm, 3, 1'b1);
      8'h22: d = mk(op_pkg::c_ret, op_pkg::s_none, 1, 1'b1);
      8'h32: d = mk(op_pkg::c_int_return, op_pkg::s_none, 1, 1'b1);
      op_pkg::OP_LONG_JUMP: d = mk(op_pkg::c_long_jump, op_pkg::s_imm, 3, 1'b1);
      8'h80: d = mk(op_pkg::c_short_jump, op_pkg::s_imm, 2, 1'b1);
      8'h40: d = mk(op_pkg::c_jc, op_pkg::s_none, 2, 1'b1);
      8'h50: d = mk(op_pkg::c_jnc, op_pkg::s_none, 2, 1'b1);
      8'h60: d = mk(op_pkg::c_jz, op_pkg::s_acc, 2, 1'b1);
      8'h70: d = mk(op_pkg::c_jnz, op_pkg::s_acc, 2, 1'b1);
      8'h20: d = mk(op_pkg::c_jb, op_pkg::s_bit, 3, 1'b1);
      8'h30: d = mk(op_pkg::c_jnb, op_pkg::s_bit, 3, 1'b1);
      8'h10: d = mk(op_pkg::c_bit_clr_br, op_pkg::s_bit, 3, 1'b1);
      8'h73: d = mk(op_pkg::c_jmp_ind, op_pkg::s_dp, 1, 1'b1);
      8'hB5: d = mk(op_pkg::c_cmp_br, op_pkg::s_dir, 3, 1'b1);
      8'hB4: d = mk(op_pkg::c_cmp_br, op_pkg::s_imm, 3, 1'b1);
      [8'hB8:8'hBF]: d = mk(op_pkg::c_cmp_br, op_pkg::s_reg, 3, 1'b1);
      [8'hB6:8'hB7]: d = mk(op_pkg::c_cmp_br, op_pkg::s_ind, 3, 1'b1);
      [8'hD8:8'hDF]: d = mk(op_pkg::c_dec_br, op_pkg::s_reg, 2, 1'b1);
      8'hD5: d = mk(op_pkg::c_dec_br, op_pkg::s_dir, 3, 1'b1);
      default: d = mk(op_pkg::c_undef, op_pkg::s_none, 1, 1'b0);
    endcase
    if (d.src == op_pkg::s_reg || d.cls == op_pkg::c_mov_reg) begin
      d.reg_sel = op[2:0];
    end else if (d.src == op_pkg::s_ind || d.cls == op_pkg::c_xdata_rd ||
                 d.cls == op_pkg::c_xdata_wr) begin
      d.reg_sel = {2'b00, op[0]};
    end
    return d;
  endfunction

  assign dec_now = decode(code_byte_i);

  // ==============================
  // fetch and issue sequencing
  always_comb begin
    next_state = state;
    next_instr = instr_o;
    next_pc = pc_o;
    next_idx = idx;
    next_issue = 1'b0;
    // no prefetch: program memory is held off while an instruction runs
    code_ready_o = (state != st_exec);
    case (state)
      st_opcode: begin
        if (code_valid_i) begin
          next_instr.dec = dec_now;
          next_instr.opcode = code_byte_i;
          next_instr.byte1 = 8'h00;
          next_instr.byte2 = 8'h00;
          next_pc = pc_o + 1'b1;
          next_idx = 2'h1;
          if (dec_now.len == op_pkg::LEN_1) begin
            next_state = st_exec;
            next_issue = 1'b1;
          end else begin
            next_state = st_operand;
          end
        end
      end
      st_operand: begin
        if (code_valid_i) begin
          if (idx == 2'h1) begin
            next_instr.byte1 = code_byte_i;
          end else begin
            next_instr.byte2 = code_byte_i;
          end
          next_pc = pc_o + 1'b1;
          next_idx = idx + 2'h1;
          if (idx + 2'h1 == instr_o.dec.len) begin
            next_state = st_exec;
            next_issue = 1'b1;
          end
        end
      end
      st_exec: begin
        if (timer_last) begin
          next_state = st_opcode;
        end
      end
      default: begin
        next_state = st_opcode;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= st_opcode;
      instr_o <= '0;
      pc_o <= PC_W'(op_pkg::PC_RESET);
      idx <= 2'h0;
      instr_valid_o <= 1'b0;
      target_o <= '0;
      code_addr_o <= '0;
    end else begin
      state <= next_state;
      instr_o <= next_instr;
      pc_o <= next_pc;
      idx <= next_idx;
      instr_valid_o <= next_issue;
      // destinations are frozen with the instruction they belong to
      if (next_issue) begin
        target_o <= next_target;
        code_addr_o <= next_code_addr;
      end
    end
  end

  branch_target_unit #(
    .PC_W(PC_W)
  ) u_target (
    .pc_next_i(next_pc),
    .instr_i(next_instr),
    .acc_i(acc_i),
    .data_pointer_i(data_pointer_i),
    .target_o(next_target),
    .code_addr_o(next_code_addr)
  );

  // ==============================
  // execute timing, counted in system clock cycles
  exec_cycle_timer #(
    .CNT_W(4)
  ) u_timer (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .load_i(next_issue),
    .count_i(next_instr.dec.cyc),
    .busy_o(exec_busy_o),
    .last_o(timer_last)
  );

  assign exec_done_o = timer_last;

  // ==============================
  // branch resolution in the last execute cycle
  always_comb begin
    taken = 1'b0;
    case (instr_o.dec.cls)
      op_pkg::c_abs_call, op_pkg::c_abs_jump, op_pkg::c_long_call,
      op_pkg::c_long_jump, op_pkg::c_short_jump, op_pkg::c_ret,
      op_pkg::c_int_return, op_pkg::c_jmp_ind: taken = 1'b1;
      op_pkg::c_jc: taken = carry_i;
      op_pkg::c_jnc: taken = !carry_i;
      op_pkg::c_jz: taken = (acc_i == 8'h00);
      op_pkg::c_jnz: taken = (acc_i != 8'h00);
      op_pkg::c_jb, op_pkg::c_bit_clr_br: taken = test_i;
      // test_i reports equality for compares, zero result for decrements
      op_pkg::c_jnb, op_pkg::c_cmp_br, op_pkg::c_dec_br: taken = !test_i;
      default: taken = 1'b0;
    endcase
  end

  assign branch_taken_o = timer_last && taken;
  assign bit_clear_o = timer_last && test_i &&
                       (instr_o.dec.cls == op_pkg::c_bit_clr_br);

  // ==============================
  // checks
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      nbytes <= 2'h0;
    end else if (code_valid_i && code_ready_o) begin
      nbytes <= (state == st_opcode) ? 2'h1 : nbytes + 2'h1;
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  fetch_length_a: assert property (
    instr_valid_o |-> nbytes == instr_o.dec.len)
    else $error("bytes fetched differ from instruction length");

  exec_stall_a: assert property (
    exec_busy_o |-> !code_ready_o)
    else $error("program memory accepted during execute");

  short_exec_a: assert property (
    instr_valid_o && instr_o.dec.cls == op_pkg::c_mov_a
      |-> !exec_done_o ##1 exec_done_o ##1 code_ready_o)
    else $error("accumulator load did not take two cycles");

  long_jump_a: assert property (
    instr_valid_o && instr_o.opcode == op_pkg::OP_LONG_JUMP
      |-> (!exec_done_o)[*3] ##1 exec_done_o && branch_taken_o
          && target_o == PC_W'({instr_o.byte1, instr_o.byte2}))
    else $error("long jump timing or destination wrong");

  reg_select_a: assert property (
    instr_valid_o && (instr_o.dec.src == op_pkg::s_reg || instr_o.dec.cls == op_pkg::c_mov_reg)
      |-> instr_o.dec.reg_sel == instr_o.opcode[2:0])
    else $error("bank register not taken from low opcode bits");

  abs_page_a: assert property (
    instr_valid_o && instr_o.opcode[3:0] == 4'h1
      |-> target_o[10:8] == instr_o.opcode[7:5] && target_o[7:0] == instr_o.byte1)
    else $error("absolute destination page wrong");

  undef_slot_a: assert property (
    instr_valid_o && instr_o.dec.cls == op_pkg::c_undef
      |-> instr_o.dec.len == op_pkg::LEN_1 && pc_o == $past(pc_o, 2) + 1'b1)
    else $error("undefined opcode did not advance by one byte");

  dp_load_a: assert property (
    instr_valid_o && instr_o.opcode == op_pkg::OP_DP_LOAD
      |-> instr_o.dec.cls == op_pkg::c_mov_dp && instr_o.dec.len == op_pkg::LEN_3
          && instr_o.dec.cyc == op_pkg::CYC_LONG)
    else $error("data pointer load decoded wrongly");

  carry_branch_a: assert property (
    exec_done_o && instr_o.dec.cls == op_pkg::c_jc |-> branch_taken_o == carry_i)
    else $error("carry branch resolved wrongly");

  bit_clear_a: assert property (
    exec_done_o && instr_o.opcode == 8'h10 |-> bit_clear_o == test_i && branch_taken_o == test_i)
    else $error("tested bit not cleared");
endmodule

// ---- tb/prog_mem_model.sv ----
// program memory model: streams opcode and operand bytes on the fetch handshake
`timescale 1ns/10ps
module prog_mem_model (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  input wire logic [11:0] fill_i,
  input wire logic code_ready_i,
  output logic [7:0] code_byte_o,
  output logic code_valid_o
);
  logic [7:0] prog [0:4095];
  logic [11:0] rd_addr;
  logic [11:0] nxt;
  logic [7:0] last_byte;
  // ==============================
  // byte stream
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_addr <= 12'h000;
      code_valid_o <= 1'b0;
      last_byte <= 8'h00;
      code_byte_o <= 8'hff;
    end else if (!(code_valid_o && !code_ready_i)) begin
      // an offered byte holds until it is taken
      nxt = rd_addr + {11'h000, code_valid_o};
      rd_addr <= nxt;
      if (nxt < fill_i && (!slow_i || $urandom_range(1) == 1)) begin
        code_valid_o <= 1'b1;
        code_byte_o <= prog[nxt];
        last_byte <= prog[nxt];
      end else begin
        // idle line shows no stale byte
        code_valid_o <= 1'b0;
        code_byte_o <= ~last_byte;
      end
    end
  end
endmodule

// ---- tb/cpu_opcode_decode_transfer_branch_tb.sv ----
// testbench: every opcode plus a random stream, checked against a reference decode
`timescale 1ns/10ps
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module cpu_opcode_decode_transfer_branch_tb;
  logic mclk_i, rst_n_i, slow, code_valid, code_ready, carry, test, reroll;
  logic [7:0] code_byte, acc, cur_op, cur_b1, cur_b2;
  logic [15:0] data_pointer, exp_pc, nxt, tgt, pc, target, code_addr;
  logic [11:0] fill;
  logic instr_valid, busy, done, taken, bclr, exp_tk;
  op_pkg::instr_t instr;
  op_pkg::op_class_t ecls;
  logic chk_cls;
  int miscompares, num_checks, cycles, issued, done_cnt, cnt, k;
  int cur_len, cur_cyc, cur_br, cur_tk, cur_rs;
  logic [7:0] ops[$], b1s[$], b2s[$];

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  prog_mem_model mem_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .slow_i(slow), .fill_i(fill),
    .code_ready_i(code_ready), .code_byte_o(code_byte), .code_valid_o(code_valid));

  cpu_opcode_decode_transfer_branch #(.PC_W(16)) dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .code_byte_i(code_byte), .code_valid_i(code_valid), .code_ready_o(code_ready),
    .acc_i(acc), .data_pointer_i(data_pointer), .carry_i(carry), .test_i(test), .instr_o(instr),
    .instr_valid_o(instr_valid), .exec_busy_o(busy), .exec_done_o(done), .pc_o(pc),
    .target_o(target), .code_addr_o(code_addr), .branch_taken_o(taken), .bit_clear_o(bclr));

  // ==============================
  // reference decode
  task automatic ref_dec(input logic [7:0] op, output int len, cyc, br, tk, rs);
    logic abs;
    abs = (op[3:0] == 4'h1);
    len = 1;
    cyc = 2;
    br = 0;
    tk = 0;
    rs = -1;
    if (op inside {[8'he8:8'hef], [8'hf8:8'hff], [8'h78:8'h7f], [8'ha8:8'haf], [8'h88:8'h8f],
        [8'hc8:8'hcf], [8'hb8:8'hbf], [8'hd8:8'hdf]}) rs = op[2:0];
    if (abs || op inside {8'he5, 8'h74, [8'h78:8'h7f], 8'hf5, [8'h76:8'h77], 8'hc5, 8'ha2,
        [8'ha8:8'haf], [8'h88:8'h8f], [8'h86:8'h87], [8'ha6:8'ha7], 8'hc0, 8'hd0, 8'h82, 8'h72,
        8'ha0, 8'hb0, 8'h92, 8'h80, 8'h40, 8'h50, 8'h60, 8'h70, [8'hd8:8'hdf]}) len = 2;
    if (op inside {8'h85, 8'h75, 8'h90, 8'h12, 8'h02, 8'h20, 8'h30, 8'h10, [8'hb4:8'hbf],
        8'hd5}) len = 3;
    if (abs || (len == 2 && !(op inside {8'he5, 8'h74, [8'h78:8'h7f], 8'hf5, [8'h76:8'h77],
        8'hc5, 8'ha2})) || len == 3 || op inside {8'h93, 8'h83, [8'he2:8'he3], 8'he0,
        [8'hf2:8'hf3], 8'hf0, 8'h22, 8'h32, 8'h73}) cyc = 4;
    if (abs || op inside {8'h02, 8'h12, 8'h80, 8'h22, 8'h32, 8'h73}) br = 1;
    if (op == 8'h40) br = 2;
    if (op == 8'h50) br = 3;
    if (op == 8'h60) br = 4;
    if (op == 8'h70) br = 5;
    if (op == 8'h20 || op == 8'h10) br = 6;
    if (op == 8'h30) br = 7;
    if (op inside {[8'hb4:8'hbf], [8'hd8:8'hdf], 8'hd5}) br = 8;
    if (br != 0) tk = abs ? 2 : (op == 8'h02 || op == 8'h12) ? 1 : (op == 8'h73) ? 5 :
      (op == 8'h22 || op == 8'h32) ? 0 : (len == 2) ? 3 : 4;
  endtask

  task automatic add_instr(input logic [7:0] op);
    int l, c, b, t, r;
    ref_dec(op, l, c, b, t, r);
    ops.push_back(op);
    b1s.push_back(8'($urandom));
    b2s.push_back(8'($urandom));
    mem_u.prog[fill] = op;
    if (l > 1) mem_u.prog[fill + 12'd1] = b1s[$];
    if (l > 2) mem_u.prog[fill + 12'd2] = b2s[$];
    fill = fill + 12'(l);
  endtask

  // ==============================
  // datapath values change only between instructions
  always @(posedge mclk_i) begin
    if (reroll) begin
      acc <= $urandom_range(3) == 0 ? 8'h00 : 8'($urandom);
      data_pointer <= 16'($urandom);
      carry <= 1'($urandom);
      test <= 1'($urandom);
      reroll = 1'b0;
    end
  end

  // ==============================
  // monitor and comparison
  always @(negedge mclk_i) begin
    if (rst_n_i && instr_valid) begin
      cur_op = ops[issued];
      cur_b1 = b1s[issued];
      cur_b2 = b2s[issued];
      issued++;
      ref_dec(cur_op, cur_len, cur_cyc, cur_br, cur_tk, cur_rs);
      nxt = exp_pc + 16'(cur_len);
      `CHK("opcode", cur_op, instr.opcode)
      `CHK("length", 2'(cur_len), instr.dec.len)
      `CHK("cycle field", 4'(cur_cyc), instr.dec.cyc)
      `CHK("next pc", nxt, pc)
      `CHK("ready in execute", 1'b0, code_ready)
      if (cur_len > 1) `CHK("byte1", cur_b1, instr.byte1)
      if (cur_len > 2) `CHK("byte2", cur_b2, instr.byte2)
      if (cur_rs >= 0) `CHK("reg select", 3'(cur_rs), instr.dec.reg_sel)
      chk_cls = 1'b1;
      ecls = op_pkg::c_undef;
      case (cur_op) inside
        8'h00: ecls = op_pkg::c_nop;
        8'h90: ecls = op_pkg::c_mov_dp;
        8'h73: ecls = op_pkg::c_jmp_ind;
        8'h10: ecls = op_pkg::c_bit_clr_br;
        [8'he8:8'hef], 8'he5, [8'he6:8'he7], 8'h74: ecls = op_pkg::c_mov_a;
        [8'hd6:8'hd7]: ecls = op_pkg::c_xch_nib;
        8'h93, 8'h83: ecls = op_pkg::c_code_load;
        8'hc0: ecls = op_pkg::c_push;
        8'hd0: ecls = op_pkg::c_pop;
        8'h04, 8'h24, 8'ha3, 8'hc2, 8'hc3, 8'hd2, 8'he4: ecls = op_pkg::c_undef;
        default: chk_cls = 1'b0;
      endcase
      if (chk_cls) `CHK("class", ecls, instr.dec.cls)
      if (cur_op == 8'h83) `CHK("code addr pc", 16'(acc) + nxt, code_addr)
      if (cur_op == 8'h93) `CHK("code addr dp", 16'(acc) + data_pointer, code_addr)
      case (cur_tk)
        1: tgt = {cur_b1, cur_b2};
        2: tgt = {nxt[15:11], cur_op[7:5], cur_b1};
        3: tgt = nxt + {{8{cur_b1[7]}}, cur_b1};
        4: tgt = nxt + {{8{cur_b2[7]}}, cur_b2};
        5: tgt = 16'(acc) + data_pointer;
        default: tgt = nxt;
      endcase
      cnt = 0;
    end
    if (rst_n_i && busy) cnt++;
    if (rst_n_i && done) begin
      `CHK("execute cycles", cur_cyc, cnt)
      case (cur_br)
        1: exp_tk = 1'b1;
        2: exp_tk = carry;
        3: exp_tk = !carry;
        4: exp_tk = (acc == 8'h00);
        5: exp_tk = (acc != 8'h00);
        6: exp_tk = test;
        7, 8: exp_tk = !test;
        default: exp_tk = 1'b0;
      endcase
      `CHK("taken", exp_tk, taken)
      `CHK("bit clear", cur_op == 8'h10 && test, bclr)
      if (cur_br != 0) `CHK("target", tgt, target)
      // pc is the fetch address; loading the target is left to the core
      exp_pc = nxt;
      done_cnt++;
      reroll = 1'b1;
    end
  end

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang guard sized well above the worst stalled stream
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    void'($urandom(88));
    rst_n_i = 1'b0;
    slow = 1'b0;
    fill = 12'h000;
    acc = 8'h00;
    data_pointer = 16'h0000;
    carry = 1'b0;
    test = 1'b0;
    reroll = 1'b0;
    exp_pc = 16'h0000;
    for (k = 0; k < 256; k++) add_instr(8'(k));
    for (k = 0; k < 300; k++) add_instr(8'($urandom));
    repeat (5) @(posedge mclk_i);
    @(negedge mclk_i);
    `CHK("ready in reset", 1'b1, code_ready)
    `CHK("pc in reset", 16'h0000, pc)
    @(posedge mclk_i);
    rst_n_i <= 1'b1;
    while (done_cnt < 256) @(posedge mclk_i);
    slow <= 1'b1;
    while (done_cnt < ops.size()) @(posedge mclk_i);
    repeat (3) @(posedge mclk_i);
    wrap_up();
  end
endmodule
